//--- logic/sci_defs.vh
// Register map, field positions and timing counts of the serial port
`ifndef SCI_DEFS_VH
`define SCI_DEFS_VH

// Register offsets
`define REG_BAUD          2'h0
`define REG_CTRL          2'h1
`define REG_STATUS        2'h2
`define REG_DATA          2'h3

// Rate register fields
`define BAUD_PRE_LSB      0
`define BAUD_RATE_LSB     4

// Control register bits
`define CTRL_TX_EMPTY_IE  7
`define CTRL_TX_DONE_IE   6
`define CTRL_RX_IE        5
`define CTRL_QUIET_IE     4
`define CTRL_XMIT_ON      3
`define CTRL_RX_ON        2
`define CTRL_RESET        8'h00

// Status flag indices (status bit = index + 1, bit 0 reads zero)
`define ST_TX_EMPTY       6
`define ST_TX_DONE        5
`define ST_RX_FULL        4
`define ST_QUIET          3
`define ST_OVERRUN        2
`define ST_NOISE          1
`define ST_FRAMING        0
`define ST_NUM            7
`define ST_FIRST_TX       5

// Prescaler divisors
`define PRE_DIV_0         6'h01
`define PRE_DIV_1         6'h03
`define PRE_DIV_2         6'h04
`define PRE_DIV_3         6'h0D
`define PRE_DIV_4         6'h27

// Sample ticks per bit and per character (10 bits)
`define TICKS_PER_BIT     4'hF
`define CHAR_TICKS        8'hA0
`define BITS_PER_FRAME    4'h9
`define SAMPLE_A          4'h7
`define SAMPLE_B          4'h8
`define SAMPLE_C          4'h9

`endif

//--- logic/baud_chain.v
// Prescaler and binary rate divider making the sample and bit ticks
`include "sci_defs.vh"

module baud_chain (
    input  wire       clk_sys,
    input  wire       rstn,
    input  wire [2:0] prescale_select,
    input  wire [2:0] rate_divider_select,
    output wire       rx_sample_clock,
    output wire       bit_tick
);
    reg  [5:0] pre_cnt_r;
    reg  [6:0] rate_cnt_r;
    reg  [3:0] bit_cnt_r;
    reg  [5:0] pre_div;
    wire       pre_tick;
    wire [6:0] rate_mask;

    always @* begin
        case (prescale_select)
            3'h0:    pre_div = `PRE_DIV_0;
            3'h1:    pre_div = `PRE_DIV_1;
            3'h2:    pre_div = `PRE_DIV_2;
            3'h3:    pre_div = `PRE_DIV_3;
            3'h4:    pre_div = `PRE_DIV_4;
            default: pre_div = `PRE_DIV_0;
        endcase
    end

    assign pre_tick        = (pre_cnt_r >= pre_div - 6'h01);
    assign rate_mask       = 7'h7F >> (3'h7 - rate_divider_select);
    assign rx_sample_clock = pre_tick & ((rate_cnt_r & rate_mask) == rate_mask);
    assign bit_tick        = rx_sample_clock & (bit_cnt_r == `TICKS_PER_BIT);

    always @(posedge clk_sys) begin
        if (!rstn) begin
            pre_cnt_r  <= 6'h00;
            rate_cnt_r <= 7'h00;
            bit_cnt_r  <= 4'h0;
        end else begin
            pre_cnt_r <= pre_tick ? 6'h00 : pre_cnt_r + 6'h01;
            if (pre_tick)
                rate_cnt_r <= rate_cnt_r + 7'h01;
            if (rx_sample_clock)
                bit_cnt_r <= bit_cnt_r + 4'h1;
        end
    end
endmodule // baud_chain

//--- logic/rx_unit.v
// Receive shifter with three-sample voting and quiet-line detection
`include "sci_defs.vh"

module rx_unit (
    input  wire       clk_sys,
    input  wire       rstn,
    input  wire       rx_sample_clock,
    input  wire       rx_on,
    input  wire       rxd,
    output reg        char_ready,
    output reg  [7:0] char_data,
    output reg        char_noise,
    output reg        char_frame,
    output reg        quiet_pulse
);
    reg       busy_r;
    reg [3:0] tick_r;
    reg [3:0] bit_r;
    reg [7:0] shift_r;
    reg [1:0] ones_r;
    reg       noisy_r;
    reg [7:0] high_cnt_r;
    reg       used_r;
    wire [1:0] votes;
    wire       maj;

    assign votes = ones_r + {1'b0, rxd};
    assign maj   = votes[1];

    always @(posedge clk_sys) begin
        if (!rstn) begin
            busy_r <= 1'b0; tick_r <= 4'h0; bit_r <= 4'h0; shift_r <= 8'h00;
            ones_r <= 2'h0; noisy_r <= 1'b0; high_cnt_r <= 8'h00; used_r <= 1'b0;
            char_ready <= 1'b0; char_data <= 8'h00; char_noise <= 1'b0;
            char_frame <= 1'b0; quiet_pulse <= 1'b0;
        end else begin
            char_ready  <= 1'b0;
            quiet_pulse <= 1'b0;
            if (rx_sample_clock && rx_on) begin
                // Idle only after a full character of ones, once per busy spell
                if (!rxd) begin
                    high_cnt_r <= 8'h00;
                    used_r     <= 1'b1;
                end else if (high_cnt_r != `CHAR_TICKS) begin
                    high_cnt_r <= high_cnt_r + 8'h01;
                    if (high_cnt_r == `CHAR_TICKS - 8'h01 && used_r) begin
                        quiet_pulse <= 1'b1;
                        used_r      <= 1'b0;
                    end
                end
                if (!busy_r) begin
                    if (!rxd) begin
                        busy_r <= 1'b1; tick_r <= 4'h0; bit_r <= 4'h0; noisy_r <= 1'b0;
                    end
                end else begin
                    tick_r <= tick_r + 4'h1;
                    if (tick_r == `TICKS_PER_BIT)
                        bit_r <= bit_r + 4'h1;
                    if (tick_r == `SAMPLE_A)
                        ones_r <= {1'b0, rxd};
                    else if (tick_r == `SAMPLE_B)
                        ones_r <= ones_r + {1'b0, rxd};
                    else if (tick_r == `SAMPLE_C) begin
                        if (votes != 2'h0 && !(ones_r == 2'h2 && rxd))
                            noisy_r <= 1'b1;
                        if (bit_r == 4'h0) begin
                            if (maj)
                                busy_r <= 1'b0;
                        end else if (bit_r == `BITS_PER_FRAME) begin
                            busy_r     <= 1'b0;
                            char_ready <= 1'b1;
                            char_data  <= shift_r;
                            char_frame <= ~maj;
                            char_noise <= noisy_r |
                                          (votes != 2'h0 && !(ones_r == 2'h2 && rxd));
                        end else
                            shift_r <= {maj, shift_r[7:1]};
                    end
                end
            end
        end
    end
endmodule // rx_unit

//--- logic/sci_port.v
// Asynchronous serial port: rate chain, transmitter, status flags
`include "sci_defs.vh"

// Notes on behaviour
// - Rate divider 1..128 after prescaler, sampling clock
// - Rate select survives reset, writable anytime
// - Bit clock is sampling clock over sixteen
// - Flags set by hardware, held until cleared
// - Enabling transmitter sets empty and complete
// - Empty flag with enable raises interrupt
// - Complete flag with enable raises interrupt
// - Disable finishes the character being shifted
// - Disable discards queued characters
// - Only reset stops transmitter at once
// - Idle disable frees pin on bit clock
// - Last character still sets both flags
// - Five receive flags, three interrupting
// - Receive full on transfer to holding
// - Overrun drops new, keeps held character
// - Overrun sets overrun, not receive full
// - Noise and framing qualify, never interrupt
// - Idle after one full character of ones
// - Quiet flag only on busy-to-idle change
// - Status read then data write clears
// - Status read then data read clears
// - Receive and quiet interrupt conditions
// - Prescaler divides by 1,3,4,13,39
module sci_port (
    input  wire       clk_sys,
    input  wire       rstn,
    input  wire [1:0] addr,
    input  wire [7:0] wr_data,
    input  wire       wr_stb,
    input  wire       rd_stb,
    output reg  [7:0] rd_data,
    input  wire       rxd_pin,
    output reg        txd_out,
    output reg        txd_owned,
    output reg        irq
);
    // Rate selects: no reset, power-up value only
    reg  [2:0]         prescale_select_r = 3'h0;
    reg  [2:0]         rate_divider_select_r = 3'h0;
    reg  [7:0]         ctrl_r;
    reg  [`ST_NUM-1:0] flag_r;
    reg  [`ST_NUM-1:0] arm_r;
    reg  [7:0]         rx_holding_reg;
    reg  [7:0]         tx_holding_reg;
    reg                hold_valid_r;
    reg                sh_busy_r;
    reg  [8:0]         sh_reg_r;
    reg  [3:0]         sh_cnt_r;
    reg                xmit_on_d_r;
    reg                rxd_s1_r;
    reg                rxd_s2_r;

    wire               rx_sample_clock;
    wire               bit_tick;
    wire               char_ready;
    wire [7:0]         char_data;
    wire               char_noise;
    wire               char_frame;
    wire               quiet_pulse;

    wire               xmit_on;
    wire               rx_on;
    wire               tx_empty_irq_en;
    wire               tx_done_irq_en;
    wire               rx_irq_en;
    wire               quiet_irq_en;

    wire               sel_wr_data;
    wire               sel_rd_data;
    wire               sel_rd_stat;
    wire               xmit_rise;
    wire               tx_start;
    wire               tx_done_ev;
    wire               overrun_ev;
    wire               accept_ev;
    wire [`ST_NUM-1:0] set_ev;
    wire [`ST_NUM-1:0] clr_ev;
    wire [7:0]         status_val;

    function sel;
        input [1:0] a;
        input [1:0] reg_off;
        begin
            sel = (a == reg_off);
        end
    endfunction

    assign xmit_on         = ctrl_r[`CTRL_XMIT_ON];
    assign rx_on           = ctrl_r[`CTRL_RX_ON];
    assign tx_empty_irq_en = ctrl_r[`CTRL_TX_EMPTY_IE];
    assign tx_done_irq_en  = ctrl_r[`CTRL_TX_DONE_IE];
    assign rx_irq_en       = ctrl_r[`CTRL_RX_IE];
    assign quiet_irq_en    = ctrl_r[`CTRL_QUIET_IE];

    assign sel_wr_data = wr_stb & sel(addr, `REG_DATA);
    assign sel_rd_data = rd_stb & sel(addr, `REG_DATA);
    assign sel_rd_stat = rd_stb & sel(addr, `REG_STATUS);
    assign status_val  = {flag_r, 1'b0};

    baud_chain u_baud (
        .clk_sys             (clk_sys),
        .rstn                (rstn),
        .prescale_select     (prescale_select_r),
        .rate_divider_select (rate_divider_select_r),
        .rx_sample_clock     (rx_sample_clock),
        .bit_tick            (bit_tick)
    );

    // Receive pin synchroniser
    always @(posedge clk_sys) begin
        if (!rstn) begin
            rxd_s1_r <= 1'b1;
            rxd_s2_r <= 1'b1;
        end else begin
            rxd_s1_r <= rxd_pin;
            rxd_s2_r <= rxd_s1_r;
        end
    end

    rx_unit u_rx (
        .clk_sys         (clk_sys),
        .rstn            (rstn),
        .rx_sample_clock (rx_sample_clock),
        .rx_on           (rx_on),
        .rxd             (rxd_s2_r),
        .char_ready      (char_ready),
        .char_data       (char_data),
        .char_noise      (char_noise),
        .char_frame      (char_frame),
        .quiet_pulse     (quiet_pulse)
    );

    // Register writes
    always @(posedge clk_sys) begin
        if (wr_stb && sel(addr, `REG_BAUD)) begin
            prescale_select_r     <= wr_data[`BAUD_PRE_LSB +: 3];
            rate_divider_select_r <= wr_data[`BAUD_RATE_LSB +: 3];
        end
    end

    always @(posedge clk_sys) begin
        if (!rstn)
            ctrl_r <= `CTRL_RESET;
        else if (wr_stb && sel(addr, `REG_CTRL))
            ctrl_r <= {wr_data[7:2], 2'h0};
    end

    // Register reads, answer in the next cycle
    always @(posedge clk_sys) begin
        if (!rstn)
            rd_data <= 8'h00;
        else if (rd_stb) begin
            case (addr)
                `REG_BAUD:   rd_data <= {1'b0, rate_divider_select_r,
                                         1'b0, prescale_select_r};
                `REG_CTRL:   rd_data <= ctrl_r;
                `REG_STATUS: rd_data <= status_val;
                `REG_DATA:   rd_data <= rx_holding_reg;
                default:     rd_data <= 8'h00;
            endcase
        end else
            rd_data <= 8'h00;
    end

    // Transmitter
    assign xmit_rise  = xmit_on & ~xmit_on_d_r;
    assign tx_start   = bit_tick & ~sh_busy_r & hold_valid_r & xmit_on;
    assign tx_done_ev = bit_tick & sh_busy_r & (sh_cnt_r == 4'h0);

    always @(posedge clk_sys) begin
        if (!rstn) begin
            xmit_on_d_r    <= 1'b0;
            hold_valid_r   <= 1'b0;
            tx_holding_reg <= 8'h00;
            sh_busy_r      <= 1'b0;
            sh_reg_r       <= 9'h1FF;
            sh_cnt_r       <= 4'h0;
            txd_out        <= 1'b1;
            txd_owned      <= 1'b0;
        end else begin
            xmit_on_d_r <= xmit_on;
            if (!xmit_on)
                hold_valid_r <= 1'b0;
            else if (sel_wr_data) begin
                hold_valid_r   <= 1'b1;
                tx_holding_reg <= wr_data;
            end else if (tx_start)
                hold_valid_r <= 1'b0;
            if (tx_start) begin
                sh_busy_r <= 1'b1;
                sh_reg_r  <= {1'b1, tx_holding_reg};
                sh_cnt_r  <= `BITS_PER_FRAME;
                txd_out   <= 1'b0;
            end else if (bit_tick && sh_busy_r) begin
                if (sh_cnt_r == 4'h0)
                    sh_busy_r <= 1'b0;
                else begin
                    txd_out  <= sh_reg_r[0];
                    sh_reg_r <= {1'b1, sh_reg_r[8:1]};
                    sh_cnt_r <= sh_cnt_r - 4'h1;
                end
            end
            if (bit_tick)
                txd_owned <= xmit_on | (sh_busy_r & ~tx_done_ev);
        end
    end

    // Receive hand-off into the holding register
    assign overrun_ev = char_ready & flag_r[`ST_RX_FULL];
    assign accept_ev  = char_ready & ~flag_r[`ST_RX_FULL];

    always @(posedge clk_sys) begin
        if (!rstn)
            rx_holding_reg <= 8'h00;
        else if (accept_ev)
            rx_holding_reg <= char_data;
    end

    // Flag set events
    assign set_ev[`ST_TX_EMPTY] = xmit_rise | tx_start | (tx_done_ev & ~xmit_on);
    assign set_ev[`ST_TX_DONE]  = xmit_rise |
                                  (tx_done_ev & ~(hold_valid_r & xmit_on));
    assign set_ev[`ST_RX_FULL]  = accept_ev;
    assign set_ev[`ST_QUIET]    = quiet_pulse;
    assign set_ev[`ST_OVERRUN]  = overrun_ev;
    assign set_ev[`ST_NOISE]    = accept_ev & char_noise;
    assign set_ev[`ST_FRAMING]  = accept_ev & char_frame;

    // Two-step clear per flag; a set in the clearing cycle wins
    genvar gi;
    generate
        for (gi = 0; gi < `ST_NUM; gi = gi + 1) begin : g_flag
            if (gi >= `ST_FIRST_TX) begin : g_tx
                assign clr_ev[gi] = arm_r[gi] & sel_wr_data;
            end else begin : g_rx
                assign clr_ev[gi] = arm_r[gi] & sel_rd_data;
            end
            always @(posedge clk_sys) begin
                if (!rstn) begin
                    flag_r[gi] <= 1'b0;
                    arm_r[gi]  <= 1'b0;
                end else begin
                    flag_r[gi] <= set_ev[gi] | (flag_r[gi] & ~clr_ev[gi]);
                    if (sel_rd_stat && flag_r[gi])
                        arm_r[gi] <= 1'b1;
                    else if (clr_ev[gi] || !flag_r[gi])
                        arm_r[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Single interrupt request
    always @(posedge clk_sys) begin
        if (!rstn)
            irq <= 1'b0;
        else
            irq <= (tx_empty_irq_en & flag_r[`ST_TX_EMPTY]) |
                   (tx_done_irq_en & flag_r[`ST_TX_DONE]) |
                   (rx_irq_en & (flag_r[`ST_RX_FULL] | flag_r[`ST_OVERRUN])) |
                   (quiet_irq_en & flag_r[`ST_QUIET]);
    end

endmodule // sci_port

//--- verif/sci_port_asserts.sv
// Checker of the serial port's bus, pin and interrupt behaviour
module sci_port_checker (
    input wire logic       clk_sys,
    input wire logic       rstn,
    input wire logic [1:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic       wr_stb,
    input wire logic       rd_stb,
    input wire logic [7:0] rd_data,
    input wire logic       rxd_pin,
    input wire logic       txd_out,
    input wire logic       txd_owned,
    input wire logic       irq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] baud_r = 8'h00;
    logic [7:0] ctrl_r;
    int         cnt_r;
    int         pre;
    int         bitlen;
    always_comb begin
        case (baud_r[2:0])
            3'h1: pre = 3;
            3'h2: pre = 4;
            3'h3: pre = 13;
            3'h4: pre = 39;
            default: pre = 1;
        endcase
        bitlen = 16 * pre * (1 << baud_r[6:4]);
    end
    // Rate fields are not reset
    always_ff @(posedge clk_sys) begin
        if (wr_stb && addr == 2'h0) begin
            baud_r <= wr_data;
        end
    end
    // Clocks since the start bit of the current transmit frame
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ctrl_r <= 8'h00;
            cnt_r  <= 0;
        end else begin
            if (wr_stb && addr == 2'h1) begin
                ctrl_r <= wr_data;
            end
            if (cnt_r != 0) begin
                cnt_r <= (cnt_r == 10 * bitlen - 1) ? 0 : cnt_r + 1;
            end else if (!txd_out && $past(txd_out)) begin
                cnt_r <= 1;
            end
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    rd_idle_a: assert property (!rd_stb |=> rd_data == 8'h00)
        else $error("read data not zero outside a read");
    status_zero_a: assert property (rd_stb && addr == 2'h2 |=> !rd_data[0])
        else $error("status bit 0 not zero");
    baud_keep_a: assert property (rd_stb && addr == 2'h0
        |=> {rd_data[6:4], rd_data[2:0]} == {baud_r[6:4], baud_r[2:0]})
        else $error("rate fields lost");
    no_enable_irq_a: assert property (ctrl_r[7:4] == 4'h0 |=> !irq)
        else $error("interrupt without enable");
    enable_irq_a: assert property ($rose(ctrl_r[3]) && ctrl_r[7] |-> ##[1:4] irq)
        else $error("no interrupt after transmitter enable");
    own_rise_a: assert property ($rose(txd_owned) |-> ctrl_r[3])
        else $error("pin taken while transmitter off");
    idle_high_a: assert property (!txd_owned |-> txd_out)
        else $error("transmit line low while pin released");
    start_len_a: assert property (cnt_r > 0 && cnt_r < bitlen |-> !txd_out)
        else $error("start bit too short");
    stop_bit_a: assert property (cnt_r >= 9 * bitlen |-> txd_out)
        else $error("stop bit not high");
    frame_own_a: assert property (cnt_r != 0 && cnt_r < 9 * bitlen |-> txd_owned)
        else $error("pin released mid character");
    cover property (cnt_r == 1);
    cover property ($rose(irq));
    cover property (rd_stb && addr == 2'h2);
endmodule // sci_port_checker

bind sci_port sci_port_checker u_sci_port_checker (
    .clk_sys(clk_sys), .rstn(rstn), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rd_data(rd_data), .rxd_pin(rxd_pin), .txd_out(txd_out),
    .txd_owned(txd_owned), .irq(irq)
);

//--- verif/remote_node.sv
// Remote serial node: sends frames on the receive line, decodes the transmit line
module remote_node (
    input  wire logic clk_sys,
    input  wire logic txd_out,
    output logic      rxd
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] got;
    int         got_n = 0;
    int         bl = 16;
    initial rxd = 1'b1;
    // Line rests high between frames
    task automatic send(input logic [7:0] d, input int b, input bit bad_stop, input bit glitch);
        logic [9:0] f;
        f = {~bad_stop, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            for (int j = 0; j < b; j++) begin
                @(posedge clk_sys);
                rxd <= (glitch && i == 1 && j == 9) ? ~f[i] : f[i];
            end
        end
        // Back to idle for a bit time, also after a bad stop bit
        @(posedge clk_sys);
        rxd <= 1'b1;
        repeat (b) @(posedge clk_sys);
    endtask
    // Decode each character at mid bit
    initial begin
        forever begin
            @(negedge txd_out);
            repeat (bl / 2) @(posedge clk_sys);
            for (int i = 0; i < 8; i++) begin
                repeat (bl) @(posedge clk_sys);
                got[i] = txd_out;
            end
            repeat (bl) @(posedge clk_sys);
            got_n++;
        end
    end
endmodule // remote_node

//--- verif/tb_top.sv
// Testbench of the serial port
`include "sci_defs.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk_sys;
    logic       rstn;
    logic [1:0] addr;
    logic [7:0] wr_data;
    logic       wr_stb;
    logic       rd_stb;
    logic [7:0] rd_data;
    logic       rxd_pin;
    logic       txd_out;
    logic       txd_owned;
    logic       irq;
    int         failures = 0;
    int         check_count = 0;
    int         cycles = 0;

    sci_port u_sci_port (.clk_sys(clk_sys), .rstn(rstn), .addr(addr), .wr_data(wr_data),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .rxd_pin(rxd_pin),
        .txd_out(txd_out), .txd_owned(txd_owned), .irq(irq));
    remote_node u_remote_node (.clk_sys(clk_sys), .txd_out(txd_out), .rxd(rxd_pin));

    always #20 clk_sys = ~clk_sys;

    task automatic results();
        $display("comparisons %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 90000) begin
            failures++;
            results();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr    <= a;
        wr_data <= d;
        wr_stb  <= 1'b1;
        @(posedge clk_sys);
        wr_stb  <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge clk_sys);
        rd_stb <= 1'b0;
        @(negedge clk_sys);
        d = rd_data;
    endtask
    // Read status until the masked flags match, bounded
    task automatic poll(input logic [7:0] m, input logic [7:0] v);
        logic [7:0] s;
        int         k;
        k = 0;
        rd(`REG_STATUS, s);
        while ((s & m) !== v && k < 12000) begin
            rd(`REG_STATUS, s);
            k++;
        end
        check(s & m, v);
    endtask
    task automatic reset();
        @(posedge clk_sys);
        rstn <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
    endtask
    task automatic t_reset();
        logic [7:0] s;
        wr(`REG_BAUD, 8'h14);
        reset();
        rd(`REG_BAUD, s);
        check(s & 8'h77, 8'h14);
        rd(`REG_CTRL, s);
        check(s, 8'h00);
        rd(`REG_STATUS, s);
        check(s, 8'h00);
        check({5'h00, txd_owned, txd_out, irq}, 8'h02);
        $display("test reset done");
    endtask
    task automatic t_rates();
        logic [7:0] s;
        logic [7:0] cfg [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h70};
        int         div [6] = '{1, 3, 4, 13, 39, 128};
        int         n;
        foreach (cfg[i]) begin
            wr(`REG_CTRL, 8'h00);
            wr(`REG_BAUD, cfg[i]);
            u_remote_node.bl = 16 * div[i];
            n = u_remote_node.got_n;
            wr(`REG_CTRL, 8'h88);
            rd(`REG_STATUS, s);
            check(s & 8'hC0, 8'hC0);
            repeat (2) @(posedge clk_sys);
            check({7'h00, irq}, 8'h01);
            wr(`REG_DATA, 8'hA5 ^ 8'(i));
            poll(8'h40, 8'h40);
            check(8'(u_remote_node.got_n - n), 8'h01);
            check(u_remote_node.got, 8'hA5 ^ 8'(i));
        end
        $display("test rates done");
    endtask
    task automatic t_tx_stop();
        logic [7:0] s;
        int         n;
        wr(`REG_BAUD, 8'h00);
        wr(`REG_CTRL, 8'h00);
        repeat (17) @(posedge clk_sys);
        check({7'h00, txd_owned}, 8'h00);
        u_remote_node.bl = 16;
        n = u_remote_node.got_n;
        wr(`REG_CTRL, 8'h08);
        rd(`REG_STATUS, s);
        wr(`REG_DATA, 8'h3C);
        rd(`REG_STATUS, s);
        check(s & 8'h40, 8'h00);
        poll(8'h80, 8'h80);
        wr(`REG_DATA, 8'hC3);
        wr(`REG_CTRL, 8'h40);
        check({7'h00, txd_owned}, 8'h01);
        poll(8'hC0, 8'hC0);
        repeat (200) @(posedge clk_sys);
        check(8'(u_remote_node.got_n - n), 8'h01);
        check(u_remote_node.got, 8'h3C);
        check({6'h00, irq, txd_owned}, 8'h02);
        wr(`REG_CTRL, 8'h00);
        $display("test transmitter stop done");
    endtask
    task automatic t_rx();
        logic [7:0] s;
        wr(`REG_CTRL, 8'h24);
        u_remote_node.send(8'h5A, 16, 1'b0, 1'b0);
        poll(8'h20, 8'h20);
        repeat (2) @(posedge clk_sys);
        check({7'h00, irq}, 8'h01);
        u_remote_node.send(8'h81, 16, 1'b0, 1'b0);
        poll(8'h28, 8'h28);
        rd(`REG_DATA, s);
        check(s, 8'h5A);
        rd(`REG_STATUS, s);
        check(s & 8'h28, 8'h00);
        wr(`REG_CTRL, 8'h14);
        poll(8'h10, 8'h10);
        repeat (2) @(posedge clk_sys);
        check({7'h00, irq}, 8'h01);
        rd(`REG_DATA, s);
        repeat (300) @(posedge clk_sys);
        rd(`REG_STATUS, s);
        check(s & 8'h10, 8'h00);
        u_remote_node.send(8'h33, 16, 1'b1, 1'b0);
        poll(8'h22, 8'h22);
        check({7'h00, irq}, 8'h00);
        rd(`REG_DATA, s);
        u_remote_node.send(8'hF0, 16, 1'b0, 1'b1);
        poll(8'h24, 8'h24);
        rd(`REG_DATA, s);
        check(s, 8'hF0);
        $display("test receiver done");
    endtask
    initial begin
        clk_sys = 1'b0;
        rstn    = 1'b0;
        addr    = 2'h0;
        wr_data = 8'h00;
        wr_stb  = 1'b0;
        rd_stb  = 1'b0;
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        t_reset();
        t_rates();
        t_tx_stop();
        t_rx();
        results();
    end
endmodule // tb_top
